/* spi_master_slave_port.sv */
/*
 * Two serial peripheral port instances behind an Avalon-MM slave with waitrequest.
 * Assumes pins are synchronous to mclk, the select pin direction comes from the GPIO port,
 * and an outside interrupt controller supplies enable and service pulses per instance.
 */
// Chosen here: the Avalon-MM register port.
// Notes on behaviour
// - Full duplex on four wires with selectable polarity, phase and bit order.
// - Writing the data byte starts a transfer; master drives the clock.
// - Slave select is an input; clock comes from outside; slave shifts both ways.
// - Completion sets the done flag; interrupt request; service clears it.
// - Interrupt disabled: status read then data access clears the done flag.
// - Data write during a transfer sets collision; same sequence clears it.
// - Slave select low activates; high stops, resets shifting, drops partial data.
// - Master seeing select low drops to slave and sets the done flag.
// - Master select as output is not driven here; GPIO owns it.
// - Select enable cleared: internal select high as master, low as slave.
// - Select rise sets its flag; only writing zero clears it.
// - Transmit and receive enables gate their pins and directions.
// - Control bit 7 enables the port.
// - Control bit 6 picks most or least significant bit first.
// - Control bit 5 picks slave or master.
// - Control bit 4 sets the serial clock idle level.
// - Control bit 3 picks leading or trailing sample edge.
// - Doubler and rate bits divide mclk by 4,16,64,128 or 2,8,32,64.
`default_nettype none

module spi_channel
   import spi_port_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire bus_req_t bus,
   input wire pins_in_t pins_in,
   input wire side_in_t side_in,
   output logic [7:0] ctrl_rd,
   output logic [7:0] flags_rd,
   output logic [7:0] data_rd,
   output var pins_out_t pins_out,
   output logic int_request
);

   // ==========================================================
   // State
   logic [7:0] ctrl_q;
   logic [2:0] cfg_q;
   logic done_q;
   logic write_collision_flag_q;
   logic sshigh_q;
   logic armed_q;
   logic [7:0] shift_q;
   logic [7:0] rx_q;
   logic out_q;
   logic sck_q;
   logic sck_prev_q;
   logic ss_prev_q;
   logic [6:0] div_q;
   logic [3:0] edge_q;
   logic [2:0] bitcnt_q;
   xfer_state_t state_q;

   logic en, master, clock_idle_level, clock_sample_edge, lsb;
   logic select_pin_enable, transmit_pin_enable, receive_pin_enable;
   logic ss_input, ss_int, mode_fault, slave_act;
   logic m_tick, lead_evt, trail_evt, sample_evt, setup_evt;
   logic rx_bit, busy, start, load, xfer_done, clear_pair, ss_rise;
   logic [7:0] shift_next;

   function automatic logic head_bit(input logic [7:0] v, input logic lsb_first);
      head_bit = lsb_first ? v[0] : v[7];
   endfunction : head_bit

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
      shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
   endfunction : shift_in

   // ==========================================================
   // Decoded configuration
   assign en = ctrl_q[CTL_EN];
   assign lsb = ctrl_q[CTL_LSB];
   assign master = ctrl_q[CTL_MS];
   assign clock_idle_level = ctrl_q[CTL_CLOCK_IDLE_LEVEL];
   assign clock_sample_edge = ctrl_q[CTL_CLOCK_SAMPLE_EDGE];
   assign select_pin_enable = cfg_q[FLG_SELECT_PIN_ENABLE];
   assign transmit_pin_enable = cfg_q[FLG_TRANSMIT_PIN_ENABLE];
   assign receive_pin_enable = cfg_q[FLG_RECEIVE_PIN_ENABLE];

   // A master whose select pin is a GPIO output never sees its own select
   assign ss_input = select_pin_enable & ~(master & side_in.ss_dir_out);
   assign ss_int = ~select_pin_enable ? master : (ss_input ? pins_in.ss_in : 1'b1);
   assign mode_fault = en & master & ~ss_int;
   assign slave_act = en & ~master & ~ss_int;
   assign ss_rise = ss_input & ~ss_prev_q & pins_in.ss_in;

   // ==========================================================
   // Edge events, shared by master generator and slave detector
   assign m_tick = (state_q == ST_MASTER) && (div_q == half_period_last(ctrl_q[CTL_DBL:CTL_RATE_LO]));
   assign lead_evt = master ? (m_tick & ~edge_q[0])
                            : (slave_act & (sck_prev_q == clock_idle_level) & (pins_in.sck_in != clock_idle_level));
   assign trail_evt = master ? (m_tick & edge_q[0])
                             : (slave_act & (sck_prev_q != clock_idle_level) & (pins_in.sck_in == clock_idle_level));
   assign sample_evt = clock_sample_edge ? trail_evt : lead_evt;
   assign setup_evt = clock_sample_edge ? lead_evt : trail_evt;

   assign rx_bit = ~receive_pin_enable ? 1'b0 : (master ? pins_in.miso_in : pins_in.mosi_in);
   assign shift_next = shift_in(shift_q, rx_bit, lsb);

   assign busy = (state_q != ST_IDLE);
   assign load = bus.wr_data & ~busy;
   assign start = load & en & master & ~mode_fault;
   assign xfer_done = master ? (m_tick && edge_q == LAST_EDGE)
                             : (sample_evt && bitcnt_q == LAST_BIT);
   assign clear_pair = armed_q & (bus.rd_data | bus.wr_data);

   // ==========================================================
   // Transfer sequencer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= ST_MASTER;
               end else if (slave_act && sample_evt) begin
                  state_q <= ST_SLAVE;
               end
            end
            ST_MASTER: begin
               if (mode_fault || !en || !master || xfer_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_SLAVE: begin
               // Select going high abandons the byte in flight
               if (!slave_act || xfer_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Clock divider and edge counter
   always_ff @(posedge mclk) begin
      if (sys_rst || state_q != ST_MASTER) begin
         div_q <= 7'h00;
         edge_q <= 4'h0;
      end else if (m_tick) begin
         div_q <= 7'h00;
         edge_q <= 4'(edge_q + 4'h1);
      end else begin
         div_q <= 7'(div_q + 7'h01);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sck_q <= 1'b0;
      end else if (state_q != ST_MASTER) begin
         sck_q <= clock_idle_level;
      end else if (m_tick) begin
         sck_q <= ~sck_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bitcnt_q <= 3'h0;
      end else if (xfer_done || (!slave_act && (state_q != ST_MASTER || !master))) begin
         bitcnt_q <= 3'h0;
      end else if (sample_evt) begin
         bitcnt_q <= 3'(bitcnt_q + 3'h1);
      end
   end

   // ==========================================================
   // Shift register and serial output
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         shift_q <= REG_RESET;
         out_q <= 1'b0;
      end else if (load) begin
         shift_q <= bus.wdata;
         // Phase 0 needs the first bit on the line before the first edge
         if (!clock_sample_edge) begin
            out_q <= head_bit(bus.wdata, lsb);
         end
      end else begin
         if (sample_evt) begin
            shift_q <= shift_next;
         end
         if (setup_evt) begin
            out_q <= head_bit(shift_q, lsb);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rx_q <= REG_RESET;
      end else if (xfer_done) begin
         rx_q <= sample_evt ? shift_next : shift_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sck_prev_q <= 1'b0;
         // Select idles high, so a low reset value would fake a rise
         ss_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= pins_in.sck_in;
         ss_prev_q <= pins_in.ss_in;
      end
   end

   // ==========================================================
   // Software registers and flags
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_q <= REG_RESET;
      end else begin
         if (bus.wr_ctrl) begin
            ctrl_q <= bus.wdata;
         end
         // Demotion wins over a concurrent software write to avoid contention
         if (mode_fault) begin
            ctrl_q[CTL_MS] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg_q <= 3'h0;
      end else if (bus.wr_flags) begin
         cfg_q <= bus.wdata[FLG_SELECT_PIN_ENABLE:FLG_RECEIVE_PIN_ENABLE];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (xfer_done || mode_fault) begin
         done_q <= 1'b1;
      end else if (side_in.int_enable && side_in.int_service) begin
         done_q <= 1'b0;
      end else if (!side_in.int_enable && clear_pair) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         write_collision_flag_q <= 1'b0;
      end else if (bus.wr_data && busy) begin
         write_collision_flag_q <= 1'b1;
      end else if (clear_pair) begin
         write_collision_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         armed_q <= 1'b0;
      end else if (bus.rd_flags) begin
         armed_q <= 1'b1;
      end else if (bus.rd_data || bus.wr_data) begin
         armed_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sshigh_q <= 1'b0;
      end else if (ss_rise) begin
         sshigh_q <= 1'b1;
      end else if (bus.wr_flags && !bus.wdata[FLG_SSHIGH]) begin
         sshigh_q <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs
   assign ctrl_rd = ctrl_q;
   assign flags_rd = {done_q, write_collision_flag_q, sshigh_q, 2'b00, cfg_q};
   assign data_rd = rx_q;
   assign int_request = done_q & side_in.int_enable;

   always_comb begin
      pins_out.sck_out = sck_q;
      pins_out.sck_oe = en & master;
      pins_out.mosi_out = out_q;
      pins_out.mosi_oe = en & master & transmit_pin_enable;
      pins_out.miso_out = out_q;
      pins_out.miso_oe = slave_act & transmit_pin_enable;
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   AST_START_MASTER: assert property (start |=> state_q == ST_MASTER)
      else $error("data write in master idle did not start a transfer");
   AST_WRITE_COLLIDE: assert property (bus.wr_data && busy |=> write_collision_flag_q)
      else $error("write during transfer did not set collision flag");
   AST_SLAVE_ABORT: assert property (!master && ss_int |=> state_q == ST_IDLE && bitcnt_q == 3'h0)
      else $error("high select did not reset slave shifting");
   AST_MODE_FAULT: assert property (mode_fault |=> !ctrl_q[CTL_MS] && done_q)
      else $error("low select on master did not demote and flag");
   AST_SS_RISE: assert property (ss_rise |=> sshigh_q)
      else $error("select rise not flagged");
   AST_SS_WRITE_ONE: assert property (!sshigh_q && !ss_rise && bus.wr_flags |=> !sshigh_q)
      else $error("writing the select flag set it");
   AST_PIN_GATE: assert property (!transmit_pin_enable |-> !pins_out.mosi_oe && !pins_out.miso_oe)
      else $error("transmit pin driven while transmit disabled");
   AST_DISABLED: assert property (!en |-> !pins_out.sck_oe ##1 state_q == ST_IDLE)
      else $error("disabled port still active");
   AST_SCK_IDLE: assert property (state_q == ST_IDLE |=> pins_out.sck_out == $past(clock_idle_level))
      else $error("serial clock not at idle level");
   AST_DONE_SET: assert property (xfer_done |=> done_q && rx_q == $past(sample_evt ? shift_next : shift_q))
      else $error("completion did not set done flag and byte");
   AST_DONE_CLEAR: assert property (!side_in.int_enable && clear_pair && !xfer_done && !mode_fault |=> !done_q)
      else $error("status then data access did not clear done flag");
   AST_DIVIDER: assert property (state_q == ST_MASTER && ctrl_q[CTL_DBL:CTL_RATE_LO] == 3'h0 && m_tick
                                 && !mode_fault && en && master && !xfer_done && !bus.wr_ctrl
                                 |=> !m_tick ##1 m_tick)
      else $error("divide by four half period is not two cycles");

endmodule : spi_channel

module spi_master_slave_port
   import spi_port_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output var logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire pins_in_t pins_in_a,
   input wire side_in_t side_in_a,
   output var pins_out_t pins_out_a,
   output logic int_request_a,
   input wire pins_in_t pins_in_b,
   input wire side_in_t side_in_b,
   output var pins_out_t pins_out_b,
   output logic int_request_b
);

   logic ack_q;
   logic take_wr, take_rd;
   bus_req_t bus_a, bus_b;
   logic [7:0] ctrl_a, flags_a, data_a, ctrl_b, flags_b, data_b;
   logic [7:0] rd_mux;

   function automatic bus_req_t decode(input logic [7:0] addr, input logic [7:0] c_idx,
                                       input logic [7:0] d_idx, input logic [7:0] f_idx,
                                       input logic wr, input logic rd, input logic [7:0] wd);
      decode.wr_ctrl = wr && addr == c_idx;
      decode.wr_data = wr && addr == d_idx;
      decode.wr_flags = wr && addr == f_idx;
      decode.rd_flags = rd && addr == f_idx;
      decode.rd_data = rd && addr == d_idx;
      decode.wdata = wd;
   endfunction : decode

   // ==========================================================
   // Bus slave: one wait cycle so read data comes from a flop
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign take_wr = ack_q & avs_write & avs_byteenable[0];
   assign take_rd = ack_q & avs_read;
   assign bus_a = decode(avs_address, CTRL_A_IDX, DATA_A_IDX, FLAGS_A_IDX, take_wr, take_rd, avs_writedata[7:0]);
   assign bus_b = decode(avs_address, CTRL_B_IDX, DATA_B_IDX, FLAGS_B_IDX, take_wr, take_rd, avs_writedata[7:0]);

   // Unmapped indices read as zero and ignore writes
   always_comb begin
      case (avs_address)
         CTRL_A_IDX: rd_mux = ctrl_a;
         DATA_A_IDX: rd_mux = data_a;
         FLAGS_A_IDX: rd_mux = flags_a;
         CTRL_B_IDX: rd_mux = ctrl_b;
         DATA_B_IDX: rd_mux = data_b;
         FLAGS_B_IDX: rd_mux = flags_b;
         default: rd_mux = REG_RESET;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         avs_readdata <= {24'h00_0000, rd_mux};
      end
   end

   // ==========================================================
   // Instances
   spi_channel u_chan_a (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .bus(bus_a),
      .pins_in(pins_in_a),
      .side_in(side_in_a),
      .ctrl_rd(ctrl_a),
      .flags_rd(flags_a),
      .data_rd(data_a),
      .pins_out(pins_out_a),
      .int_request(int_request_a)
   );

   spi_channel u_chan_b (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .bus(bus_b),
      .pins_in(pins_in_b),
      .side_in(side_in_b),
      .ctrl_rd(ctrl_b),
      .flags_rd(flags_b),
      .data_rd(data_b),
      .pins_out(pins_out_b),
      .int_request(int_request_b)
   );

endmodule : spi_master_slave_port

`default_nettype wire

/* spi_port_pkg.sv */
/*
 * Shared constants, types and helpers for the dual-instance serial peripheral port.
 * Assumes a single 100 MHz clock and register indices that the bus slave maps at four bytes apart.
 */
`default_nettype none

package spi_port_pkg;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] CTRL_A_IDX = 8'hd2;
   localparam logic [7:0] DATA_A_IDX = 8'hd3;
   localparam logic [7:0] FLAGS_A_IDX = 8'hd4;
   localparam logic [7:0] CTRL_B_IDX = 8'h92;
   localparam logic [7:0] DATA_B_IDX = 8'h93;
   localparam logic [7:0] FLAGS_B_IDX = 8'hf1;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ==========================================================
   // Control register fields
   localparam int CTL_EN = 7;
   localparam int CTL_LSB = 6;
   localparam int CTL_MS = 5;
   localparam int CTL_CLOCK_IDLE_LEVEL = 4;
   localparam int CTL_CLOCK_SAMPLE_EDGE = 3;
   localparam int CTL_DBL = 2;
   localparam int CTL_RATE_HI = 1;
   localparam int CTL_RATE_LO = 0;

   // ==========================================================
   // Flags register fields
   localparam int FLG_DONE = 7;
   localparam int FLG_WRITE_COLLISION_FLAG = 6;
   localparam int FLG_SSHIGH = 5;
   localparam int FLG_SELECT_PIN_ENABLE = 2;
   localparam int FLG_TRANSMIT_PIN_ENABLE = 1;
   localparam int FLG_RECEIVE_PIN_ENABLE = 0;

   // ==========================================================
   // Sequencing counts
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [7:0] RATIO_N0 = 8'h04;
   localparam logic [7:0] RATIO_N1 = 8'h10;
   localparam logic [7:0] RATIO_N2 = 8'h40;
   localparam logic [7:0] RATIO_N3 = 8'h80;
   localparam logic [7:0] RATIO_D0 = 8'h02;
   localparam logic [7:0] RATIO_D1 = 8'h08;
   localparam logic [7:0] RATIO_D2 = 8'h20;
   localparam logic [7:0] RATIO_D3 = 8'h40;

   typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} xfer_state_t;

   typedef struct packed {
      logic sck_in;
      logic mosi_in;
      logic miso_in;
      logic ss_in;
   } pins_in_t;

   typedef struct packed {
      logic sck_out;
      logic sck_oe;
      logic mosi_out;
      logic mosi_oe;
      logic miso_out;
      logic miso_oe;
   } pins_out_t;

   typedef struct packed {
      logic ss_dir_out;
      logic int_enable;
      logic int_service;
   } side_in_t;

   typedef struct packed {
      logic wr_ctrl;
      logic wr_data;
      logic wr_flags;
      logic rd_flags;
      logic rd_data;
      logic [7:0] wdata;
   } bus_req_t;

   // Clock cycles per half period of the serial clock, less one
   function automatic logic [6:0] half_period_last(input logic [2:0] sel);
      logic [7:0] ratio;
      case (sel)
         3'h0: ratio = RATIO_N0;
         3'h1: ratio = RATIO_N1;
         3'h2: ratio = RATIO_N2;
         3'h3: ratio = RATIO_N3;
         3'h4: ratio = RATIO_D0;
         3'h5: ratio = RATIO_D1;
         3'h6: ratio = RATIO_D2;
         default: ratio = RATIO_D3;
      endcase
      half_period_last = 7'(ratio[7:1] - 7'h01);
   endfunction : half_period_last

endpackage : spi_port_pkg

`default_nettype wire

/* spi_slave_model.sv */
/* Outside serial slave facing port A: mode 0, most significant bit first.
   Assumes its clock and data lines only change on mclk edges. */
`default_nettype none
module spi_slave_model (
   input wire logic mclk,
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_q = 1'b0;
   logic idle_q = 1'b0;
   logic [7:0] sh = 8'h00;
   // ==========================================
   // Shifter
   // Released line toggles so stale data never reads as valid
   assign miso = sel_n ? idle_q : sh[7];
   initial rx = 8'h00;
   always @(posedge mclk) begin
      sck_q <= sck;
      idle_q <= ~idle_q;
      if (sel_n) begin
         sh <= tx;
      end else if (sck && !sck_q) begin
         rx <= {rx[6:0], mosi};
      end else if (!sck && sck_q) begin
         sh <= {sh[6:0], 1'b0};
      end
   end
endmodule : spi_slave_model
`default_nettype wire

/* tb_spi_master_slave_port.sv */
/* Testbench for the two-instance serial port: port A talks to a model slave.
   Assumes the design answers every bus request after one wait cycle. */
`default_nettype none
module tb_spi_master_slave_port import spi_port_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd_r = 1'b0;
   logic wr_r = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_r;
   pins_out_t pout_a;
   logic irq_a;
   logic ss_a = 1'b1;
   logic sck_m = 1'b0;
   logic mosi_m = 1'b0;
   logic int_en = 1'b0;
   logic svc = 1'b0;
   logic sel_n = 1'b1;
   logic [7:0] mtx = 8'h00;
   logic [7:0] mrx;
   logic miso;
   int num_errors = 0;
   int checks = 0;

   spi_master_slave_port dut_u (.mclk(mclk), .sys_rst(sys_rst), .avs_address(addr), .avs_read(rd_r),
      .avs_write(wr_r), .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
      .avs_waitrequest(wait_r), .pins_in_a({sck_m, mosi_m, miso, ss_a}), .side_in_a({1'b0, int_en, svc}),
      .pins_out_a(pout_a), .int_request_a(irq_a), .pins_in_b('0), .side_in_b('0), .pins_out_b(),
      .int_request_b());
   spi_slave_model slave_u (.mclk(mclk), .sck(pout_a.sck_out), .mosi(pout_a.mosi_out), .sel_n(sel_n),
      .tx(mtx), .miso(miso), .rx(mrx));

   // ==========================================
   // Clock, bus and checking helpers
   initial forever #5 mclk = ~mclk;

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      addr <= a;
      wdata <= {24'h0, d};
      wr_r <= w;
      rd_r <= ~w;
      do @(posedge mclk); while (wait_r !== 1'b0);
      q = rdata[7:0];
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(n, e, q);
   endtask : rd

   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // ==========================================
   // Scenarios
   task automatic reset_values();
      logic [7:0] idx [7] = '{CTRL_A_IDX, DATA_A_IDX, FLAGS_A_IDX, CTRL_B_IDX, DATA_B_IDX, FLAGS_B_IDX, 8'h00};
      foreach (idx[i]) rd(idx[i], 8'h00, "reset value");
      wr(CTRL_B_IDX, 8'h5c);
      rd(CTRL_B_IDX, 8'h5c, "ctrl b");
   endtask : reset_values

   // Master exchange with a collision write while the byte is on the wire
   task automatic xfer(input logic [7:0] c, d, s, em, ed);
      logic [7:0] q;
      mtx <= s;
      @(posedge mclk);
      sel_n <= 1'b0;
      wr(CTRL_A_IDX, c);
      wr(DATA_A_IDX, d);
      wr(DATA_A_IDX, 8'hff);
      do bus(1'b0, FLAGS_A_IDX, 8'h00, q); while (q[FLG_DONE] !== 1'b1);
      chk("flags done", 8'hc3, q);
      rd(DATA_A_IDX, ed, "rx byte");
      rd(FLAGS_A_IDX, 8'h03, "flags cleared");
      chk("slave rx", em, mrx);
      sel_n <= 1'b1;
   endtask : xfer

   task automatic mode_fault();
      logic [7:0] q;
      wr(FLAGS_A_IDX, 8'h07);
      wr(CTRL_A_IDX, 8'ha0);
      int_en <= 1'b1;
      ss_a <= 1'b0;
      do @(posedge mclk); while (irq_a !== 1'b1);
      rd(CTRL_A_IDX, 8'h80, "master bit");
      rd(FLAGS_A_IDX, 8'h87, "fault flags");
      svc <= 1'b1;
      @(posedge mclk);
      svc <= 1'b0;
      @(posedge mclk);
      #1;
      chk("irq", 8'h00, {7'h0, irq_a});
      ss_a <= 1'b1;
      do bus(1'b0, FLAGS_A_IDX, 8'h00, q); while (q[FLG_SSHIGH] !== 1'b1);
      wr(FLAGS_A_IDX, 8'h27);
      rd(FLAGS_A_IDX, 8'h27, "rise kept");
      wr(FLAGS_A_IDX, 8'h07);
      rd(FLAGS_A_IDX, 8'h07, "rise cleared");
      wr(CTRL_A_IDX, 8'h20);
      wr(DATA_A_IDX, 8'h55);
      rd(FLAGS_A_IDX, 8'h07, "disabled port");
   endtask : mode_fault

   // Port A as slave, mode 0, clocked by the bench as outside master
   task automatic slave_xfer();
      logic [7:0] got;
      got = 8'h00;
      wr(CTRL_A_IDX, 8'h80);
      wr(DATA_A_IDX, 8'h96);
      ss_a <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_m <= 1'((8'h3b >> i) & 8'h01);
         repeat (2) @(posedge mclk);
         got[i] = pout_a.miso_out;
         sck_m <= 1'b1;
         repeat (2) @(posedge mclk);
         sck_m <= 1'b0;
      end
      repeat (3) @(posedge mclk);
      chk("slave tx", 8'h96, got);
      rd(DATA_A_IDX, 8'h3b, "slave rx");
      rd(FLAGS_A_IDX, 8'h87, "slave done");
      ss_a <= 1'b1;
   endtask : slave_xfer

   initial begin
      #200000;
      num_errors++;
      test_done();
   end

   initial begin
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      reset_values();
      wr(FLAGS_A_IDX, 8'h03);
      xfer(8'ha0, 8'ha5, 8'h3c, 8'ha5, 8'h3c);
      xfer(8'he0, 8'h01, 8'h07, 8'h80, 8'he0);
      xfer(8'ha5, 8'h5a, 8'hc3, 8'h5a, 8'hc3);
      mode_fault();
      slave_xfer();
      test_done();
   end
endmodule : tb_spi_master_slave_port
`default_nettype wire
